//--- core/slice_alu.sv
// Combinational arithmetic unit of the slice: decrement and masked AND.
// Assumes its operands are stable within the cycle; it holds no state.
`timescale 1ns/1ps
`include "slice_defines.svh"
module slice_alu
  import slice_pkg::*;
(
  input  wire logic     do_and,
  input  wire word_t    operand_a,
  input  wire word_t    operand_b,
  input  wire word_t    mask_term,
  input  wire logic     carry_in,
  output alu_out_t      result
);
  // The decrement is A plus all ones plus carry-in; with carry forced low the
  // sum is A minus one, wrapping, and the carry is high unless A was zero.
  logic [`SLICE_WIDTH:0] sum;
  word_t                 and_value;

  assign sum       = {1'b0, operand_a} + {1'b0, mask_term} +
                     {{`SLICE_WIDTH{1'b0}}, carry_in};
  assign and_value = operand_a & operand_b & mask_term;
  // AND reports carry as the OR of the bits of the masked result, a logical carry.
  assign result = do_and ? {and_value, |and_value} :
                           {sum[`SLICE_WIDTH-1:0], sum[`SLICE_WIDTH]};
endmodule

//--- core/slice_datapath.sv
// Decrement and AND datapath of one bit-slice processing element.
// Assumes the microinstruction and input bus come from logic on CLK.
//
// Behaviour
// - Work decrement subtracts one from work or temp register, writes it back there.
// - Input decrement stores input bus minus one in work or temp register, carry out.
// - Scratch decrement writes entry minus one to entry and address latch.
// - AND combines two sources bitwise and stores result in destination.
// - An optional mask value also enters the AND, masking the result.
// - Register AND combines work register, scratch entry, optional mask; result to entry.
`timescale 1ns/1ps
`include "slice_defines.svh"
module slice_datapath
  import slice_pkg::*;
#(
  parameter int SCRATCH_COUNT = `SCRATCH_COUNT
)
(
  input  wire logic     CLK,
  input  wire logic     ARST_N,
  input  wire micro_t   MICRO,
  input  wire word_t    INPUT_BUS,
  output word_t         PRIMARY_WORK_REGISTER,
  output word_t         TEMP_REGISTER,
  output word_t         MEMORY_ADDRESS_LATCH,
  output word_t         SCRATCH_READ,
  output logic          CARRY_OUTPUT
);
  // The slice takes one microinstruction on each rising edge of CLK and shows every result
  // straight after that edge. Operations may follow each other on every cycle with no idle
  // cycle between them, because each operand is read from the registers as they stand before
  // the edge. The microinstruction and the input bus come from logic on the same clock, so
  // they are read directly with no synchroniser in front of them.

  // Registers held by the slice.
  word_t                     acc;
  word_t                     temp;
  word_t                     addr_latch;
  word_t                     scratch [SCRATCH_COUNT];
  logic                      carry;

  // Combinational decode and datapath wires.
  alu_out_t                  alu_res;
  word_t                     work_sel;
  word_t                     scratch_val;
  word_t                     op_a;
  word_t                     op_b;
  word_t                     mask_term;
  logic                      do_and;
  logic                      write_work;
  logic                      write_scratch;
  logic                      write_addr;
  logic                      update_carry;
  logic                      sel_ok;

  // One-hot operation decode and next values of the registers.
  logic                      is_nop;
  logic                      is_work_dec;
  logic                      is_load_input;
  logic                      is_scratch_dec;
  logic                      is_and_reg;
  logic                      is_and_input;
  logic                      dest_is_temp;
  logic                      write_acc;
  logic                      write_temp;
  logic                      alu_carry_in;
  word_t                     full_mask;
  word_t                     next_acc;
  word_t                     next_temp;
  word_t                     next_entry;
  word_t                     next_addr;
  logic                      next_carry;

  // Compares the function field with one code. Every decode goes through this one place,
  // so a wider field or a recoded operation changes a single definition and cannot leave
  // one of the decode wires behind.
  function automatic logic func_is(input logic [`FUNC_W-1:0] code,
                                   input logic [`FUNC_W-1:0] want);
    return code == want;
  endfunction

  // Tells whether a selector names an entry that exists. The selector field has more codes than
  // the file has entries, so the spare codes must be caught before they index the array; both
  // the read view and the write enable rely on it.
  function automatic logic entry_exists(input logic [`SCRATCH_IDX_W-1:0] idx);
    return 32'(idx) < SCRATCH_COUNT;
  endfunction

  // One wire per operation. Codes 6 and 7 match none of them, so they write no register;
  // they still refresh the carry from the decrement path, which microcode must not rely on.
  assign is_nop         = func_is(MICRO.func, `FUNC_NOP);
  assign is_work_dec    = func_is(MICRO.func, `FUNC_WORK_DEC);
  assign is_load_input  = func_is(MICRO.func, `FUNC_LOAD_INPUT);
  assign is_scratch_dec = func_is(MICRO.func, `FUNC_SCRATCH_DEC);
  assign is_and_reg     = func_is(MICRO.func, `FUNC_AND_REG);
  assign is_and_input   = func_is(MICRO.func, `FUNC_AND_INPUT);
  assign dest_is_temp   = MICRO.dest_temp == `DEST_TEMP;
  assign do_and         = is_and_reg || is_and_input;

  // Read side of the scratch file and of the work pair. An out-of-range selector reads as
  // zero rather than as whatever the array model returns for a missing entry.
  assign sel_ok      = entry_exists(MICRO.scratch_sel);
  assign scratch_val = sel_ok ? scratch[MICRO.scratch_sel] : '0;
  assign work_sel    = dest_is_temp ? temp : acc;

  // The sequencer is trusted to send all ones and carry zero for a decrement; the mask is
  // used as given there so that a slip in microcode shows up in the result rather than
  // hiding. An AND with no mask supplied behaves as if an all-ones mask had been given,
  // so the mask field may hold anything while the mask flag is low.
  assign full_mask    = {`SLICE_WIDTH{1'b1}};
  assign mask_term    = (do_and && !MICRO.mask_given) ? full_mask : MICRO.mask;
  assign alu_carry_in = ~MICRO.force_carry_zero;

  // Operand A is the value being decremented, or the work register for either AND.
  // Operand B is only read by the AND forms: the scratch entry or the input bus.
  // A decrement never reads operand B, so its choice there does not matter.
  assign op_a = is_load_input  ? INPUT_BUS   :
                is_scratch_dec ? scratch_val :
                do_and         ? acc         :
                                 work_sel;
  assign op_b = is_and_reg ? scratch_val : INPUT_BUS;

  // Write enables. The work pair shares one enable split by the destination bit, so a
  // single microinstruction can never write both registers. A scratch write past the end
  // of the file is dropped, while the address latch still takes the result.
  assign write_work    = is_work_dec || is_load_input || is_and_input;
  assign write_acc     = write_work && !dest_is_temp;
  assign write_temp    = write_work && dest_is_temp;
  assign write_scratch = sel_ok && (is_scratch_dec || is_and_reg);
  assign write_addr    = is_scratch_dec;
  assign update_carry  = !is_nop;

  // Arithmetic unit; it is purely combinational, so every result lands on the edge that
  // takes the microinstruction. The carry-in is the inverse of the force-zero flag, so a
  // decrement is operand plus all ones with no carry.
  slice_alu alu (
    .do_and    (do_and),
    .operand_a (op_a),
    .operand_b (op_b),
    .mask_term (mask_term),
    .carry_in  (alu_carry_in),
    .result    (alu_res)
  );

  // Next values. The work pair, the latch and the carry each either take the unit's result or keep their own value,
  // which keeps their clocked processes below down to a reset and a copy; the scratch file is written through its enable.
  assign next_acc   = write_acc ? alu_res.value : acc;
  assign next_temp  = write_temp ? alu_res.value : temp;
  assign next_entry = alu_res.value;
  assign next_addr  = write_addr ? alu_res.value : addr_latch;
  assign next_carry = update_carry ? alu_res.carry : carry;

  // Work register.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      acc <= `WORK_RESET;
    end else begin
      acc <= next_acc;
    end
  end

  // Temporary register; it shares the reset value of the work register.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      temp <= `WORK_RESET;
    end else begin
      temp <= next_temp;
    end
  end

  // Scratch file. Only the addressed entry is written, so the file needs no next value
  // for each entry; the enable already excludes selectors past the end.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      for (int i = 0; i < SCRATCH_COUNT; i++) begin
        scratch[i] <= `SCRATCH_RESET;
      end
    end else if (write_scratch) begin
      scratch[MICRO.scratch_sel] <= next_entry;
    end
  end

  // Memory address latch; it follows only the scratch decrement.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      addr_latch <= `ADDR_RESET;
    end else begin
      addr_latch <= next_addr;
    end
  end

  // Carry flag; a no-op leaves it standing so that microcode can test it later.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      carry <= 1'b0;
    end else begin
      carry <= next_carry;
    end
  end

  // Outputs. The scratch view is combinational: it follows the selector within the cycle,
  // so the sequencer can read an entry without spending an operation on it.
  assign PRIMARY_WORK_REGISTER = acc;
  assign TEMP_REGISTER         = temp;
  assign MEMORY_ADDRESS_LATCH  = addr_latch;
  assign SCRATCH_READ          = scratch_val; // Combinational view of the selected entry.
  assign CARRY_OUTPUT          = carry;
endmodule

//--- core/slice_defines.svh
// Constants for the bit-slice decrement and AND datapath.
// Assumes inclusion by the package and by the datapath modules.
`ifndef SLICE_DEFINES_SVH
`define SLICE_DEFINES_SVH
`define SLICE_WIDTH       8
`define SCRATCH_COUNT     10
`define SCRATCH_IDX_W     4
`define WORK_RESET        8'h00
`define SCRATCH_RESET     8'h00
`define ADDR_RESET        8'h00
`define FUNC_W            3
`define FUNC_NOP          3'h0
`define FUNC_WORK_DEC     3'h1
`define FUNC_LOAD_INPUT   3'h2
`define FUNC_SCRATCH_DEC  3'h3
`define FUNC_AND_REG      3'h4
`define FUNC_AND_INPUT    3'h5
`define DEST_ACC          1'b0
`define DEST_TEMP         1'b1
`endif

//--- core/slice_pkg.sv
// Types shared by the bit-slice datapath files.
// Assumes the defines header sits beside it.
`include "slice_defines.svh"
package slice_pkg;
  typedef logic [`SLICE_WIDTH-1:0] word_t;

  // One microinstruction as presented to the slice each cycle.
  typedef struct packed {
    logic [`FUNC_W-1:0]        func;
    logic                      dest_temp;
    logic [`SCRATCH_IDX_W-1:0] scratch_sel;
    logic                      mask_given;
    word_t                     mask;
    logic                      force_carry_zero;
  } micro_t;

  // Result of the arithmetic unit.
  typedef struct packed {
    word_t value;
    logic  carry;
  } alu_out_t;
endpackage

//--- verif/sequencer_model.sv
// Sequencer model that builds each microinstruction for the slice.
// Assumes the bench picks the operation; this side fixes mask and carry fields.
`timescale 1ns/1ps
module sequencer_model
  import slice_pkg::*;
(
  input  wire logic [2:0] func,
  input  wire logic       dest,
  input  wire logic [3:0] sel,
  input  wire logic       mask_given,
  input  wire word_t      mask,
  output micro_t          micro
);
  // Decrements force the all-ones mask; every operation forces carry-in to zero.
  wire dec = func inside {3'h1, 3'h2, 3'h3};
  assign micro = '{func, dest, sel, mask_given && !dec, dec ? 8'hFF : mask, 1'b1};
endmodule

//--- verif/slice_datapath_assertions.sv
// Checker for the slice datapath, bound to its top ports.
// Assumes func codes from the shared defines header.
`timescale 1ns/1ps
`include "slice_defines.svh"
module slice_datapath_assertions
  import slice_pkg::*;
(
  input wire logic   CLK,
  input wire logic   ARST_N,
  input wire micro_t MICRO,
  input wire word_t  INPUT_BUS,
  input wire word_t  PRIMARY_WORK_REGISTER,
  input wire word_t  TEMP_REGISTER,
  input wire word_t  MEMORY_ADDRESS_LATCH,
  input wire word_t  SCRATCH_READ,
  input wire logic   CARRY_OUTPUT
);
  // Short aliases keep each property brief; an absent mask acts as all ones.
  wire [2:0] f   = MICRO.func;
  wire word_t acc = PRIMARY_WORK_REGISTER;
  wire word_t k   = MICRO.mask_given ? MICRO.mask : 8'hFF;
  // Expected AND results as plain signals, so that $past is handed a signal only.
  wire word_t and_in_exp  = acc & INPUT_BUS & k;
  wire word_t and_reg_exp = acc & SCRATCH_READ & k;
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  sequence and_reg_held;
    f == `FUNC_AND_REG && MICRO.scratch_sel < `SCRATCH_COUNT ##1 $stable(MICRO.scratch_sel);
  endsequence
  a_work_dec: assert property (f == `FUNC_WORK_DEC && !MICRO.dest_temp |=>
    acc == $past(acc) - 8'h01) else $error("work decrement result wrong");
  a_dec_carry: assert property (f == `FUNC_WORK_DEC && !MICRO.dest_temp |=>
    CARRY_OUTPUT == ($past(acc) != 8'h00)) else $error("decrement carry wrong");
  a_input_dec: assert property (f == `FUNC_LOAD_INPUT && MICRO.dest_temp |=>
    TEMP_REGISTER == $past(INPUT_BUS) - 8'h01) else $error("input decrement wrong");
  a_scratch_latch: assert property (
    f == `FUNC_SCRATCH_DEC && MICRO.scratch_sel < `SCRATCH_COUNT |=>
    MEMORY_ADDRESS_LATCH == $past(SCRATCH_READ) - 8'h01) else $error("latch value wrong");
  a_and_input: assert property (f == `FUNC_AND_INPUT && MICRO.dest_temp |=>
    TEMP_REGISTER == $past(and_in_exp)) else $error("input AND wrong");
  a_and_reg: assert property (and_reg_held |->
    SCRATCH_READ == $past(and_reg_exp)) else $error("register AND wrong");
  a_nop_hold: assert property (f == `FUNC_NOP |=> $stable(CARRY_OUTPUT) && $stable(acc))
    else $error("no-op changed state");
endmodule
bind slice_datapath slice_datapath_assertions u_slice_datapath_assertions (.CLK, .ARST_N,
  .MICRO, .INPUT_BUS, .PRIMARY_WORK_REGISTER, .TEMP_REGISTER, .MEMORY_ADDRESS_LATCH,
  .SCRATCH_READ, .CARRY_OUTPUT);

//--- verif/testbench.sv
// Self-checking bench for the slice datapath, fed through the sequencer model.
// Assumes a 25 MHz clock and the func codes of the defines header.
`timescale 1ns/1ps
`include "slice_defines.svh"
module testbench import slice_pkg::*;;
  logic clk = 0, arst_n = 0, d = 0, g = 0;
  logic [2:0] f = 3'h0;
  logic [3:0] s = 4'h0;
  word_t m = 8'hFF, ib = 8'h00, pw, t, ma, sr;
  logic cy;
  micro_t mi;
  int err_count = 0, check_count = 0;
  sequencer_model u_sequencer_model (.func(f), .dest(d), .sel(s), .mask_given(g), .mask(m),
    .micro(mi));
  slice_datapath u_slice_datapath (.CLK(clk), .ARST_N(arst_n), .MICRO(mi), .INPUT_BUS(ib),
    .PRIMARY_WORK_REGISTER(pw), .TEMP_REGISTER(t), .MEMORY_ADDRESS_LATCH(ma),
    .SCRATCH_READ(sr), .CARRY_OUTPUT(cy));
  task chk(string n, word_t seen, word_t exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // One operation per call; func returns to no-op on the executing edge.
  task op(logic [2:0] fn, logic dt, logic [3:0] sl, logic mg, word_t mk, word_t in);
    @(posedge clk) {f, d, s, g, m, ib} <= {fn, dt, sl, mg, mk, in};
    @(posedge clk) f <= 3'h0;
    #1;
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task t_input_dec;
    word_t v[3] = '{8'h00, 8'h01, 8'h80};
    foreach (v[i]) begin
      op(`FUNC_LOAD_INPUT, i[0], 4'h0, 1'b0, 8'hFF, v[i]);
      chk("dest", i[0] ? t : pw, v[i] - 8'h01);
      chk("carry", {7'h00, cy}, {7'h00, v[i] != 8'h00});
    end
    $display("input decrement done");
  endtask
  task t_work_dec;
    op(`FUNC_LOAD_INPUT, 1'b0, 4'h0, 1'b0, 8'hFF, 8'h01);
    op(`FUNC_WORK_DEC, 1'b0, 4'h0, 1'b0, 8'hFF, 8'h00);
    chk("work", pw, 8'hFF);
    chk("carry", {7'h00, cy}, 8'h00);
    op(`FUNC_WORK_DEC, 1'b1, 4'h0, 1'b0, 8'hFF, 8'h00);
    chk("temp", t, 8'hFF);
    $display("work decrement done");
  endtask
  // Entry 9 is the last scratch entry, the boundary of the file.
  task t_scratch;
    op(`FUNC_SCRATCH_DEC, 1'b0, 4'h9, 1'b0, 8'hFF, 8'h00);
    op(`FUNC_SCRATCH_DEC, 1'b0, 4'h9, 1'b0, 8'hFF, 8'h00);
    chk("scratch", sr, 8'hFE);
    chk("latch", ma, 8'hFE);
    chk("carry", {7'h00, cy}, 8'h01);
    op(`FUNC_LOAD_INPUT, 1'b0, 4'h9, 1'b0, 8'hFF, 8'h3D);
    op(`FUNC_AND_REG, 1'b0, 4'h9, 1'b1, 8'h0F, 8'h00);
    chk("and reg", sr, 8'h0C);
    op(`FUNC_AND_INPUT, 1'b1, 4'h0, 1'b1, 8'h18, 8'hF0);
    chk("and input", t, 8'h10);
    // Without a mask the AND acts as if all ones were given, whatever the mask field holds.
    op(`FUNC_AND_INPUT, 1'b0, 4'h0, 1'b0, 8'h00, 8'h0F);
    chk("and no mask", pw, 8'h0C);
    $display("scratch and AND done");
  endtask
  // Reset must leave every register, the file entry in view and the carry clear.
  task t_reset;
    #1;
    chk("reset", pw | t | ma | sr, 8'h00);
    chk("reset carry", {7'h00, cy}, 8'h00);
    $display("reset check done");
  endtask
  initial forever #20 clk = ~clk;
  // Watchdog allows many times the expected run.
  initial begin
    #40000;
    err_count++;
    summarize;
  end
  initial begin
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    t_reset;
    t_input_dec;
    t_work_dec;
    t_scratch;
    summarize;
  end
endmodule
